// ### rtl/osd_vsync_pkg.sv
// Constants for the display vsync interrupt source and its register map
package osd_vsync_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_CLAMP  = 16'h3fd1;
	localparam logic [15:0] IDX_DOT    = 16'h3fd2;
	localparam logic [15:0] IDX_DISP1  = 16'h3fc8;
	localparam logic [15:0] IDX_DISP3  = 16'h3fb9;
	localparam logic [15:0] IDX_ICR    = 16'h3fe8;
	localparam logic [15:0] IDX_MEMORY_CONTROL_REGISTER = 16'h3fe9;
	localparam logic [15:0] IDX_PSW    = 16'h3fea;
	localparam logic [15:0] IDX_STAT   = 16'h3feb;
	localparam logic [15:0] IDX_MASK   = 16'h3fec;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CLAMP_BIT   = 3;
	localparam int SYNMODE_BIT = 4;
	localparam int EXTSEL_BIT  = 5;
	localparam int CLKSEL_LSB  = 0;
	localparam int AUTO_BIT    = 0;
	localparam int ACTEXT_BIT  = 1;
	localparam int VERTICAL_MASK_ENABLE_BIT   = 7;
	localparam int LVL_LSB     = 6;
	localparam int IE_BIT      = 1;
	localparam int IR_BIT      = 0;
	localparam int FWE_BIT     = 2;
	localparam int MIE_BIT     = 6;
	localparam int IM_LSB      = 4;
	localparam int ST_EDGE     = 0;
	localparam int ST_ACK      = 1;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [1:0]  LVL_OFF    = 2'h3;
	localparam logic [19:0] VSYNC_VEC  = 20'h04074;

	typedef enum logic [1:0] {
		CLK_OSC  = 2'b00,
		CLK_X4   = 2'b01,
		CLK_OSC2 = 2'b10,
		CLK_BAD  = 2'b11
	} clk_sel_e;

	typedef enum logic [1:0] {
		SRC_INT   = 2'b00,
		SRC_SEP   = 2'b01,
		SRC_HSYNC = 2'b10
	} src_e;

endpackage

// ### rtl/vsync_edge.sv
// Optional pin synchroniser with glitch filter and rising edge pulse
`timescale 1ns/1ps
module vsync_edge #(
	parameter bit SYNC = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sig_in,
	output logic      rise
);
	logic stable_q;
	logic rise_q;

	assign rise = rise_q;

	generate
		if (SYNC)
		begin : g_pin
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge clk)
			begin
				s1_q <= sig_in;
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
			// A level counts only once the last two stages agree
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					stable_q <= 1'b0;
					rise_q   <= 1'b0;
				end
				else
				begin
					if (s2_q == s3_q)
						stable_q <= s3_q;
					rise_q <= (s2_q == s3_q) && s3_q && !stable_q;
				end
			end
		end
		else
		begin : g_logic
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					stable_q <= 1'b0;
					rise_q   <= 1'b0;
				end
				else
				begin
					stable_q <= sig_in;
					rise_q   <= sig_in && !stable_q;
				end
			end
		end
	endgenerate
endmodule

// ### rtl/osd_vsync_irq.sv
// Display vsync interrupt source, request logic and AHB-Lite register slave
`timescale 1ns/1ps
// What this block does
// R1 - Maskable source, vector 04074, levels 0-2
// R2 - Internal mode: request on generator vsync rise
// R3 - External mode: request on separated video vsync
// R4 - Clock select 00/01/10; 11 refused
// R5 - Clamp bit 3 picks digital or sliced
// R6 - Display control one bit 4: sync mode
// R7 - Display control three bit 0: auto change
// R8 - Bit 5 picks separator or hsync pin
// R9 - Dot control bit 7 enables vsync masking
// R10 - Display vsync kept apart from servo vsync
// R11 - Status mask bits gate accepted request levels
// R12 - Control bits 7:6 level; 11 disables
// R13 - Control bit 1 enables the source
// R14 - Flag set on request, cleared on accept
// R15 - Flag writes need memory control bit 2
// R16 - Software leaves flag alone after setup
// R17 - Init: save, mask, clear, enable, restore
// R18 - Request shown only when flag, enable, accepted
// R19 - Pin inputs synchronised (generator vsync is not), one flag per rise
module osd_vsync_irq (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        tv_sync_vsync,
	input  wire logic        composite_video_vsync,
	input  wire logic        hsync_pin,
	input  wire logic        ext_sync_present,
	input  wire logic        vsync_mask_window,
	input  wire logic        int_ack,
	output logic             cpu_irq,
	output logic [19:0]      irq_vector,
	output logic [1:0]       clk_sel,
	output logic             clamp_power_on,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  clamp_q;
	logic [7:0]  dot_q;
	logic [7:0]  disp1_q;
	logic [7:0]  disp3_q;
	logic [7:0]  icr_q;
	logic        flag_q;
	logic [7:0]  memory_control_register_q;
	logic [7:0]  psw_q;
	logic [1:0]  stat_q;
	logic [1:0]  mask_q;
	logic        cpu_irq_q;
	logic        irq_q;
	logic [31:0] hrdata_q;
	logic        wr_pend_q;
	logic        wr_hit_q;
	logic [15:0] wr_idx_q;
	logic        ext_mode;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Zero wait states: read data is fetched in the address phase, so
	// a read right after a write to the same register needs an idle cycle
	logic        bus_acc;
	logic        addr_ok;
	logic [15:0] addr_idx;
	logic [7:0]  rd_byte;
	logic        wr_en;
	logic [7:0]  wbyte;

	assign bus_acc  = hsel && htrans[1] && hready;
	assign addr_idx = haddr[17:2];
	assign addr_ok  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
	assign wr_en    = wr_pend_q && wr_hit_q;
	assign wbyte    = hwdata[7:0];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_hit_q  <= 1'b0;
			wr_idx_q  <= 16'h0000;
		end
		else if (hready)
		begin
			wr_pend_q <= bus_acc && hwrite;
			wr_hit_q  <= addr_ok;
			wr_idx_q  <= addr_idx;
		end
	end

	always_comb
	begin
		rd_byte = 8'h00;
		if (addr_ok)
		begin
			unique case (addr_idx)
				osd_vsync_pkg::IDX_CLAMP:  rd_byte = clamp_q;
				osd_vsync_pkg::IDX_DOT:    rd_byte = dot_q;
				osd_vsync_pkg::IDX_DISP1:  rd_byte = disp1_q;
				osd_vsync_pkg::IDX_DISP3:
				begin
					rd_byte = disp3_q;
					rd_byte[osd_vsync_pkg::ACTEXT_BIT] = ext_mode;
				end
				osd_vsync_pkg::IDX_ICR:
				begin
					rd_byte = icr_q;
					rd_byte[osd_vsync_pkg::IR_BIT] = flag_q;
				end
				osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER: rd_byte = memory_control_register_q;
				osd_vsync_pkg::IDX_PSW:    rd_byte = psw_q;
				osd_vsync_pkg::IDX_STAT:   rd_byte = {6'h00, stat_q};
				osd_vsync_pkg::IDX_MASK:   rd_byte = {6'h00, mask_q};
				default:                   rd_byte = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hrdata_q <= 32'h00000000;
		else if (bus_acc && !hwrite)
			hrdata_q <= {24'h000000, rd_byte};
		else if (hready)
			hrdata_q <= 32'h00000000;
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			clamp_q  <= osd_vsync_pkg::BYTE_RST;
			dot_q    <= osd_vsync_pkg::BYTE_RST;
			disp3_q  <= osd_vsync_pkg::BYTE_RST;
			memory_control_register_q <= osd_vsync_pkg::BYTE_RST;
			psw_q    <= osd_vsync_pkg::BYTE_RST;
			mask_q   <= 2'b00;
		end
		else if (wr_en)
		begin
			unique case (wr_idx_q)
				osd_vsync_pkg::IDX_CLAMP:  clamp_q <= wbyte; // R5
				osd_vsync_pkg::IDX_DOT:    dot_q <= wbyte; // R9
				osd_vsync_pkg::IDX_DISP3:  disp3_q <= wbyte; // R7
				osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER: memory_control_register_q <= wbyte;
				osd_vsync_pkg::IDX_PSW:    psw_q <= wbyte; // R11
				osd_vsync_pkg::IDX_MASK:   mask_q <= wbyte[1:0];
				default:                   mask_q <= mask_q;
			endcase
		end
	end

	// The forbidden clock code is dropped; the old selection stays
	always_ff @(posedge clk)
	begin
		if (rst)
			disp1_q <= osd_vsync_pkg::BYTE_RST;
		else if (wr_en && wr_idx_q == osd_vsync_pkg::IDX_DISP1)
		begin
			disp1_q[7:2] <= wbyte[7:2];
			if (wbyte[1:0] != osd_vsync_pkg::CLK_BAD) // R4
				disp1_q[1:0] <= wbyte[1:0];
		end
	end

	assign clk_sel        = disp1_q[osd_vsync_pkg::CLKSEL_LSB +: 2];
	assign clamp_power_on = clamp_q[osd_vsync_pkg::CLAMP_BIT]; // R5
	assign irq_vector     = osd_vsync_pkg::VSYNC_VEC; // R1

	// ----------------------------------------------------------------
	// Vsync source selection
	// ----------------------------------------------------------------
	// Only the display vsync enters; the servo vsync has its own path
	logic int_rise;
	logic sep_rise;
	logic hs_rise;
	logic mask_gate;
	logic src_rise;
	logic edge_ev;
	osd_vsync_pkg::src_e src;

	vsync_edge #(.SYNC(1'b0)) u_int_edge ( // R10
		.clk    (clk),
		.rst    (rst),
		.sig_in (tv_sync_vsync),
		.rise   (int_rise)
	);

	vsync_edge #(.SYNC(1'b1)) u_sep_edge ( // R19
		.clk    (clk),
		.rst    (rst),
		.sig_in (composite_video_vsync),
		.rise   (sep_rise)
	);

	vsync_edge #(.SYNC(1'b1)) u_hs_edge ( // R19
		.clk    (clk),
		.rst    (rst),
		.sig_in (hsync_pin),
		.rise   (hs_rise)
	);

	// Auto change follows sync presence instead of the mode bit
	assign ext_mode = disp3_q[osd_vsync_pkg::AUTO_BIT] ? ext_sync_present // R7
		: disp1_q[osd_vsync_pkg::SYNMODE_BIT]; // R6

	always_comb
	begin
		if (!ext_mode)
			src = osd_vsync_pkg::SRC_INT;
		else if (disp1_q[osd_vsync_pkg::EXTSEL_BIT]) // R8
			src = osd_vsync_pkg::SRC_HSYNC;
		else
			src = osd_vsync_pkg::SRC_SEP;
	end

	// Edges are picked after detection so a source switch makes no edge
	always_comb
	begin
		unique case (src)
			osd_vsync_pkg::SRC_INT:   src_rise = int_rise; // R2
			osd_vsync_pkg::SRC_SEP:   src_rise = sep_rise; // R3
			osd_vsync_pkg::SRC_HSYNC: src_rise = hs_rise; // R8
			default:                  src_rise = 1'b0;
		endcase
	end

	assign mask_gate = dot_q[osd_vsync_pkg::VERTICAL_MASK_ENABLE_BIT] && vsync_mask_window; // R9
	assign edge_ev   = src_rise && !mask_gate;

	// ----------------------------------------------------------------
	// Request flag and acceptance
	// ----------------------------------------------------------------
	logic       icr_wr;
	logic       flag_we;
	logic [1:0] lvl;
	logic [1:0] im;
	logic       accepted;

	assign icr_wr  = wr_en && (wr_idx_q == osd_vsync_pkg::IDX_ICR);
	assign flag_we = memory_control_register_q[osd_vsync_pkg::FWE_BIT];
	assign lvl     = icr_q[osd_vsync_pkg::LVL_LSB +: 2];
	assign im      = psw_q[osd_vsync_pkg::IM_LSB +: 2];
	assign accepted = psw_q[osd_vsync_pkg::MIE_BIT] // R11
		&& (lvl != osd_vsync_pkg::LVL_OFF) && (lvl < im); // R12

	always_ff @(posedge clk)
	begin
		if (rst)
			icr_q <= osd_vsync_pkg::BYTE_RST;
		else if (icr_wr)
			icr_q <= {wbyte[7:1], 1'b0}; // R12 R13
	end

	// A new edge beats an acceptance or a software clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			flag_q <= 1'b0;
		else if (edge_ev)
			flag_q <= 1'b1; // R14
		else if (int_ack)
			flag_q <= 1'b0; // R14
		else if (icr_wr && flag_we)
			flag_q <= wbyte[osd_vsync_pkg::IR_BIT]; // R15
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cpu_irq_q <= 1'b0;
		else
			cpu_irq_q <= flag_q && icr_q[osd_vsync_pkg::IE_BIT] && accepted; // R18
	end

	assign cpu_irq = cpu_irq_q;

	// ----------------------------------------------------------------
	// Event status and system interrupt
	// ----------------------------------------------------------------
	logic [1:0] stat_set;
	logic [1:0] stat_clr;

	assign stat_set = {int_ack, edge_ev};
	assign stat_clr = (wr_en && wr_idx_q == osd_vsync_pkg::IDX_STAT) ? wbyte[1:0] : 2'b00;

	always_ff @(posedge clk)
	begin
		if (rst)
			stat_q <= 2'b00;
		else
			stat_q <= (stat_q & ~stat_clr) | stat_set;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(stat_q & mask_q);
	end

	assign irq = irq_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_req_ready;
		flag_q && icr_q[osd_vsync_pkg::IE_BIT] && accepted;
	endsequence

	sequence s_int_edge;
		!ext_mode && int_rise && !mask_gate;
	endsequence

	sequence s_sep_edge;
		ext_mode && !disp1_q[osd_vsync_pkg::EXTSEL_BIT] && sep_rise && !mask_gate;
	endsequence

	chk_edge_sets_flag: assert property (edge_ev |=> flag_q) // R19
		else $error("vsync edge did not set the request flag");
	chk_ack_clears_flag: assert property (int_ack && !edge_ev |=> !flag_q) // R14
		else $error("acceptance did not clear the request flag");
	chk_request_shown: assert property (s_req_ready |=> cpu_irq_q) // R18
		else $error("ready request not presented");
	chk_mie_blocks: assert property (!psw_q[osd_vsync_pkg::MIE_BIT] |=> !cpu_irq_q) // R11
		else $error("request presented with master enable off");
	chk_level_gate: assert property (cpu_irq_q |-> $past(lvl) < $past(im)) // R11
		else $error("request level not accepted by mask level");
	chk_level_off: assert property (lvl == osd_vsync_pkg::LVL_OFF |=> !cpu_irq_q) // R12
		else $error("disabled level still requests");
	chk_enable_off: assert property (!icr_q[osd_vsync_pkg::IE_BIT] |=> !cpu_irq_q) // R13
		else $error("request presented while source disabled");
	chk_internal_src: assert property (s_int_edge |=> flag_q) // R2
		else $error("internal vsync edge lost");
	chk_external_src: assert property (s_sep_edge |=> flag_q) // R3
		else $error("separated vsync edge lost");
	chk_clk_sel_legal: assert property (clk_sel != osd_vsync_pkg::CLK_BAD) // R4
		else $error("forbidden clock select stored");
	chk_flag_guard: assert property (icr_wr && !flag_we && !flag_q && !edge_ev |=> !flag_q) // R15
		else $error("flag written without write enable");
	chk_vsync_mask: assert property (mask_gate && src_rise && !int_ack && !icr_wr // R9
		|=> $stable(flag_q))
		else $error("masked vsync raised a request");
endmodule

// ### verification/cpu_side_model.sv
// Behavioural CPU acceptance logic and vsync sources facing the interrupt block
`timescale 1ns/1ps
module cpu_side_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic cpu_irq,
	input  wire logic ack_en,
	output logic      int_ack,
	output logic      vs_int,
	output logic      vs_ext
);
	logic [1:0] hold_q;

	initial
	begin
		vs_int = 1'b0;
		vs_ext = 1'b0;
	end

	// Hold-off after each accept: the request falls a cycle after the flag
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			int_ack <= 1'b0;
			hold_q  <= 2'd0;
		end
		else if (hold_q != 2'd0)
		begin
			int_ack <= 1'b0;
			hold_q  <= hold_q - 2'd1;
		end
		else
		begin
			int_ack <= ack_en && cpu_irq;
			hold_q  <= (ack_en && cpu_irq) ? 2'd3 : 2'd0;
		end
	end

	// Two separate vsync lines, never merged
	task automatic pulse(input bit ext);
		if (ext)
			vs_ext <= 1'b1;
		else
			vs_int <= 1'b1;
		repeat (4) @(posedge clk);
		vs_int <= 1'b0;
		vs_ext <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the display vsync interrupt block
`timescale 1ns/1ps
module tb;
	logic        clk, rst, hsel, hwrite, hreadyout, hresp, rd_ph, hs_pin;
	logic        tv_v, cv_v, ext_pres, mwin, int_ack, ack_en, cpu_irq, irq, clamp_on;
	logic [1:0]  htrans, clk_sel;
	logic [2:0]  hsize;
	logic [19:0] vec;
	logic [31:0] haddr, hwdata, hrdata, rnd;
	logic [7:0]  exp_q[$];
	int          failures, checked;

	osd_vsync_irq i_dut (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tv_sync_vsync(tv_v), .composite_video_vsync(cv_v), .hsync_pin(hs_pin),
		.ext_sync_present(ext_pres), .vsync_mask_window(mwin), .int_ack(int_ack),
		.cpu_irq(cpu_irq), .irq_vector(vec), .clk_sel(clk_sel),
		.clamp_power_on(clamp_on), .irq(irq)
	);
	cpu_side_model i_cpu (
		.clk(clk), .rst(rst), .cpu_irq(cpu_irq), .ack_en(ack_en),
		.int_ack(int_ack), .vs_int(tv_v), .vs_ext(cv_v)
	);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checked++;
		if (seen !== expv)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic stop_test();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic addr_ph(input logic [15:0] idx, input logic w);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {14'h0000, idx, 2'b00};
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		addr_ph(idx, 1'b1);
		hwdata <= {24'h000000, d};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	// Leading idle cycle keeps a read clear of a write just before it
	task automatic rd(input logic [15:0] idx, input logic [7:0] e);
		@(posedge clk);
		addr_ph(idx, 1'b0);
		exp_q.push_back(e);
		rd_ph <= 1'b1;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd_ph <= 1'b0;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic acc();
		ack_en <= 1'b1;
		wt(8);
		ack_en <= 1'b0;
	endtask

	always @(posedge clk)
		if (rd_ph === 1'b1 && hreadyout === 1'b1)
			chk(hrdata, {24'h000000, exp_q.pop_front()});

	initial
	begin
		#400000;
		failures++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		failures = 0;
		checked  = 0;
		rst      = 1'b1;
		hsel     = 1'b0;
		htrans   = 2'b00;
		haddr    = 32'h00000000;
		hwrite   = 1'b0;
		hsize    = 3'b010;
		hwdata   = 32'h00000000;
		rd_ph    = 1'b0;
		ext_pres = 1'b0;
		mwin     = 1'b0;
		hs_pin   = 1'b0;
		ack_en   = 1'b0;
		rnd      = 32'h000021ec;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		wt(4);
		chk(clk_sel, 32'h0);
		chk(vec, osd_vsync_pkg::VSYNC_VEC);
		chk(hresp, 32'h0);
		rd(osd_vsync_pkg::IDX_ICR, 8'h00);
		rd(16'h0001, 8'h00);
		$display("test reset done");
		wr(osd_vsync_pkg::IDX_DISP1, 8'h01);
		wr(osd_vsync_pkg::IDX_DISP1, 8'h03);
		wt(2);
		chk(clk_sel, 32'h1);
		wr(osd_vsync_pkg::IDX_DISP1, 8'h02);
		wt(2);
		chk(clk_sel, 32'h2);
		repeat (4)
		begin
			rnd = lfsr(rnd);
			wr(osd_vsync_pkg::IDX_CLAMP, rnd[7:0]);
			wt(2);
			chk(clamp_on, rnd[3]);
		end
		$display("test clock and clamp done");
		wr(osd_vsync_pkg::IDX_MASK, 8'h01);
		wr(osd_vsync_pkg::IDX_PSW, 8'h30);
		wr(osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER, 8'h04);
		wr(osd_vsync_pkg::IDX_ICR, 8'h00);
		wr(osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER, 8'h00);
		wr(osd_vsync_pkg::IDX_ICR, 8'h02);
		wr(osd_vsync_pkg::IDX_PSW, 8'h70);
		i_cpu.pulse(1'b0);
		chk(cpu_irq, 32'h1);
		chk(irq, 32'h1);
		rd(osd_vsync_pkg::IDX_ICR, 8'h03);
		acc();
		chk(cpu_irq, 32'h0);
		rd(osd_vsync_pkg::IDX_ICR, 8'h02);
		wr(osd_vsync_pkg::IDX_STAT, 8'h03);
		wt(2);
		chk(irq, 32'h0);
		$display("test request and accept done");
		wr(osd_vsync_pkg::IDX_ICR, 8'h00);
		i_cpu.pulse(1'b0);
		chk(cpu_irq, 32'h0);
		rd(osd_vsync_pkg::IDX_ICR, 8'h01);
		wr(osd_vsync_pkg::IDX_ICR, 8'h02);
		rd(osd_vsync_pkg::IDX_ICR, 8'h03);
		wr(osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER, 8'h04);
		wr(osd_vsync_pkg::IDX_ICR, 8'h02);
		wr(osd_vsync_pkg::IDX_MEMORY_CONTROL_REGISTER, 8'h00);
		rd(osd_vsync_pkg::IDX_ICR, 8'h02);
		$display("test enable and flag guard done");
		for (int p = 0; p < 8; p++)
			for (int l = 0; l < 4; l++)
			begin
				wr(osd_vsync_pkg::IDX_PSW, {1'b0, p[2:0], 4'h0});
				wr(osd_vsync_pkg::IDX_ICR, {l[1:0], 6'h02});
				i_cpu.pulse(1'b0);
				chk(cpu_irq, p[2] && l != 3 && l < p[1:0]);
				wr(osd_vsync_pkg::IDX_PSW, 8'h70);
				wr(osd_vsync_pkg::IDX_ICR, 8'h02);
				acc();
			end
		$display("test level table done");
		wr(osd_vsync_pkg::IDX_DISP1, 8'h10);
		i_cpu.pulse(1'b0);
		chk(cpu_irq, 32'h0);
		i_cpu.pulse(1'b1);
		wt(4);
		chk(cpu_irq, 32'h1);
		acc();
		wr(osd_vsync_pkg::IDX_DISP3, 8'h01);
		i_cpu.pulse(1'b1);
		wt(4);
		chk(cpu_irq, 32'h0);
		ext_pres <= 1'b1;
		i_cpu.pulse(1'b1);
		wt(4);
		chk(cpu_irq, 32'h1);
		acc();
		ext_pres <= 1'b0;
		wr(osd_vsync_pkg::IDX_DISP3, 8'h00);
		// External mode with the horizontal sync pin as source
		wr(osd_vsync_pkg::IDX_DISP1, 8'h30);
		rd(osd_vsync_pkg::IDX_DISP3, 8'h02);
		i_cpu.pulse(1'b1);
		wt(4);
		chk(cpu_irq, 32'h0);
		hs_pin <= 1'b1;
		wt(6);
		hs_pin <= 1'b0;
		wt(4);
		chk(cpu_irq, 32'h1);
		acc();
		wr(osd_vsync_pkg::IDX_DISP1, 8'h00);
		wr(osd_vsync_pkg::IDX_DOT, 8'h80);
		mwin <= 1'b1;
		i_cpu.pulse(1'b0);
		chk(cpu_irq, 32'h0);
		mwin <= 1'b0;
		i_cpu.pulse(1'b0);
		chk(cpu_irq, 32'h1);
		acc();
		$display("test sources and masking done");
		stop_test();
	end
endmodule
